// ===== common/serial_mem_pkg.sv
/*
 * shared constants and carrier types for the serial memory read path.
 * assumes a byte-wide memory of 2**13 locations behind a two-wire bus.
 */
package serial_mem_pkg;

    // ==========================================================
    // address latch and row layout
    localparam int          ADDR_W      = 13;          // internal address latch width
    localparam int          ADDR_HI_W   = 5;           // bits carried by first address byte
    localparam int          ROW_LSB     = 3;           // 8-byte rows, 64 bits each
    localparam int          ROW_W       = ADDR_W - ROW_LSB;
    localparam int          SEL_W       = 3;           // device-select pin count

    // ==========================================================
    // bit positions inside the target address byte
    localparam int          RW_BIT      = 0;
    localparam int          SEL_LSB     = 1;
    localparam int          TYPE_LSB    = 4;

    // ==========================================================
    // byte framing
    localparam logic [3:0]  BIT_ZERO    = 4'h0;
    localparam logic [3:0]  BIT_ONE     = 4'h1;
    localparam logic [3:0]  BIT_LAST    = 4'h7;
    localparam logic [3:0]  BIT_FULL    = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 13'h0001;
    localparam logic [ADDR_W-1:0] ADDR_RST  = 13'h0000;

    // ==========================================================
    // bus sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_AHI,
        ST_ALO,
        ST_TX,
        ST_SKIP
    } state_type;

    // read request towards the memory array
    typedef struct packed {
        logic              rd;
        logic [ADDR_W-1:0] addr;
    } mem_req_type;

    // one endurance cycle charged to a row
    typedef struct packed {
        logic              valid;
        logic [ROW_W-1:0]  row;
    } row_touch_type;

endpackage : serial_mem_pkg

// ===== rtl/sync_edge.sv
/*
 * two-flop synchroniser with edge detection for a group of pins.
 * assumes inputs are asynchronous to clk; edges are found one stage later.
 */
`timescale 1ns/100ps
`default_nettype none

module sync_edge #(
    parameter int               WIDTH     = 2,                // number of pins
    parameter logic [WIDTH-1:0] RESET_VAL = '0                // level assumed at reset
) (
    input  wire logic             clk,                        // system clock
    input  wire logic             rst,                        // async reset, high
    input  wire logic [WIDTH-1:0] din,                        // raw pin levels
    output logic      [WIDTH-1:0] level,                      // synchronised level
    output logic      [WIDTH-1:0] rise,                       // one-cycle rising edge
    output logic      [WIDTH-1:0] fall                        // one-cycle falling edge
);

    // an empty pin group leaves nothing to synchronise
    if (WIDTH < 1)
    begin : g_width_check
        $error("sync_edge WIDTH must be at least one");
    end

    // ==========================================================
    // stage registers
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] prev_d;

    // next values: the first stage feeds only the second
    always_comb
    begin
        meta_d = din;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    // registers only
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
            prev_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // edges compare the two settled stages
    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = ~sync_q & prev_q;

endmodule : sync_edge

`default_nettype wire

// ===== rtl/serial_memory_read_path.sv
/*
 * read path of a two-wire serial memory target: target address match and
 * address load, current-address and sequential reads, row endurance events.
 * assumes mem_rdata answers one clk after a read request, and a bus clock
 * far slower than clk so every edge is seen.
 */
`timescale 1ns/100ps
`default_nettype none

module serial_memory_read_path #(
    parameter logic [3:0] DEVICE_TYPE = 4'h5                  // arbitrary device-type code
) (
    input  wire logic                                  clk,                // 200 MHz clock
    input  wire logic                                  rst,                // async reset, high
    input  wire logic                                  scl_i,              // bus clock pin
    input  wire logic                                  sda_i,              // data pin level
    output logic                                       sda_o,              // data pin drive value
    output logic                                       sda_oe_n,           // low while driving
    input  wire logic [serial_mem_pkg::SEL_W-1:0]      device_select_pins, // select straps
    output serial_mem_pkg::mem_req_type                mem_req,            // array read
    input  wire logic [7:0]                            mem_rdata,          // array data
    output serial_mem_pkg::row_touch_type              row_touch           // endurance event
);
    import serial_mem_pkg::*;
    // ==========================================================
    // pin synchronisers
    logic [1:0]       bus_lvl;
    logic [1:0]       bus_rise;
    logic [1:0]       bus_fall;
    logic [SEL_W-1:0] sel_lvl;

    sync_edge #(
        .WIDTH     (2),
        .RESET_VAL (2'h3)
    ) u_bus_sync (
        .clk   (clk),
        .rst   (rst),
        .din   ({scl_i, sda_i}),
        .level (bus_lvl),
        .rise  (bus_rise),
        .fall  (bus_fall)
    );
    sync_edge #(
        .WIDTH     (SEL_W),
        .RESET_VAL ('0)
    ) u_sel_sync (
        .clk   (clk),
        .rst   (rst),
        .din   (device_select_pins),
        .level (sel_lvl),
        .rise  (),
        .fall  ()
    );
    // bus events; start and stop are sda edges while scl is high
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise  = bus_rise[1];
    assign scl_fall  = bus_fall[1];
    assign bus_start = bus_fall[0] & bus_lvl[1];
    assign bus_stop  = bus_rise[0] & bus_lvl[1];

    // address byte match against type code and select pins
    function automatic logic addr_match(input logic [7:0] b, input logic [SEL_W-1:0] sel);
        addr_match = (b[7:TYPE_LSB] == DEVICE_TYPE) && (b[TYPE_LSB-1:SEL_LSB] == sel);
    endfunction : addr_match
    // ==========================================================
    // sequencer state
    state_type         state_q,  state_d;
    logic [3:0]        cnt_q,    cnt_d;      // bits moved in current byte
    logic              ack_q,    ack_d;      // in the ninth-clock slot
    logic              take_q,   take_d;     // byte accepted, ack due
    logic              more_q,   more_d;     // master acked a read byte
    logic              rw_q,     rw_d;       // read requested
    logic [7:0]        sh_q,     sh_d;       // shift register
    logic [ADDR_W-1:0] addr_q,   addr_d;     // internal address latch
    logic [7:0]        rdat_q,   rdat_d;     // prefetched byte
    logic              pend_q,   pend_d;     // array answer due
    logic              oen_q,    oen_d;      // registered output enable
    mem_req_type       req_q,    req_d;
    row_touch_type     touch_q,  touch_d;
    // next-state computation for the whole bus sequencer
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        ack_d   = ack_q;
        take_d  = take_q;
        more_d  = more_q;
        rw_d    = rw_q;
        sh_d    = sh_q;
        addr_d  = addr_q;
        oen_d   = oen_q;
        pend_d  = req_q.rd;
        rdat_d  = pend_q ? mem_rdata : rdat_q;
        req_d   = '{rd: 1'b0, addr: addr_q};
        touch_d = '{valid: 1'b0, row: addr_q[ADDR_W-1:ROW_LSB]};
        // start anywhere, even in ack slot
        if (bus_start)
        begin
            state_d = ST_DEV;
            cnt_d   = BIT_ZERO;
            ack_d   = 1'b0;
            take_d  = 1'b0;
            more_d  = 1'b0;
            oen_d   = 1'b1;
        end
        // stop releases the line and ends
        else if (bus_stop)
        begin
            state_d = ST_IDLE;
            ack_d   = 1'b0;
            oen_d   = 1'b1;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE, ST_SKIP:
                begin
                    oen_d = 1'b1;
                end
                ST_DEV, ST_AHI, ST_ALO:
                begin
                    if (scl_rise && !ack_q && cnt_q != BIT_FULL)
                    begin
                        sh_d  = {sh_q[6:0], bus_lvl[0]};
                        cnt_d = cnt_q + BIT_ONE;
                        if (cnt_q == BIT_LAST)
                        begin
                            take_d = 1'b1;
                            if (state_q == ST_DEV && !addr_match(sh_d, sel_lvl))
                            begin
                                state_d = ST_SKIP;
                                take_d  = 1'b0;
                            end
                            // fetch at once for next clock
                            else if (state_q == ST_DEV)
                            begin
                                rw_d          = sh_d[RW_BIT];
                                req_d.rd      = sh_d[RW_BIT];
                                touch_d.valid = sh_d[RW_BIT];
                            end
                            else if (state_q == ST_AHI)
                            begin
                                addr_d[ADDR_W-1:ADDR_W-ADDR_HI_W] = sh_d[ADDR_HI_W-1:0];
                            end
                            else
                            begin
                                addr_d[7:0] = sh_d;
                            end
                        end
                    end
                    // ack by pulling the line low
                    else if (scl_fall && take_q)
                    begin
                        take_d = 1'b0;
                        ack_d  = 1'b1;
                        oen_d  = 1'b0;
                    end
                    else if (scl_fall && ack_q)
                    begin
                        ack_d = 1'b0;
                        cnt_d = BIT_ZERO;
                        oen_d = 1'b1;
                        if (state_q == ST_DEV && rw_q)
                        begin
                            // read from the latch as loaded
                            state_d = ST_TX;
                            sh_d    = rdat_q;
                            oen_d   = rdat_q[7];
                            cnt_d   = BIT_ONE;
                        end
                        // write direction goes to address bytes
                        else if (state_q != ST_ALO)
                        begin
                            state_d = (state_q == ST_DEV) ? ST_AHI : ST_ALO;
                        end
                        // write data is not served here
                        else
                        begin
                            state_d = ST_SKIP;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall && !ack_q && cnt_q != BIT_FULL)
                    begin
                        sh_d  = {sh_q[6:0], 1'b0};
                        oen_d = sh_q[6];
                        cnt_d = cnt_q + BIT_ONE;
                    end
                    // step just before the ack slot
                    else if (scl_fall && !ack_q)
                    begin
                        addr_d = addr_q + ADDR_STEP;
                        oen_d  = 1'b1;
                        ack_d  = 1'b1;
                        more_d = 1'b0;
                    end
                    // ack asks for the next byte
                    else if (scl_rise && ack_q && !bus_lvl[0])
                    begin
                        more_d        = 1'b1;
                        req_d.rd      = 1'b1;
                        touch_d.valid = 1'b1;
                    end
                    // nack ends, stop or start follows
                    else if (scl_rise && ack_q)
                    begin
                        state_d = ST_SKIP;
                        ack_d   = 1'b0;
                    end
                    else if (scl_fall && ack_q && more_q)
                    begin
                        ack_d = 1'b0;
                        sh_d  = rdat_q;
                        oen_d = rdat_q[7];
                        cnt_d = BIT_ONE;
                    end
                end
                default:
                begin
                    state_d = ST_IDLE;
                    oen_d   = 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // registers only; the latch survives everything but reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= BIT_ZERO;
            ack_q   <= 1'b0;
            take_q  <= 1'b0;
            more_q  <= 1'b0;
            rw_q    <= 1'b0;
            sh_q    <= 8'h00;
            addr_q  <= ADDR_RST;
            rdat_q  <= 8'h00;
            pend_q  <= 1'b0;
            oen_q   <= 1'b1;
            req_q   <= '0;
            touch_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            ack_q   <= ack_d;
            take_q  <= take_d;
            more_q  <= more_d;
            rw_q    <= rw_d;
            sh_q    <= sh_d;
            addr_q  <= addr_d;
            rdat_q  <= rdat_d;
            pend_q  <= pend_d;
            oen_q   <= oen_d;
            req_q   <= req_d;
            touch_q <= touch_d;
        end
    end

    // open drain: only ever pulls low
    assign sda_o     = 1'b0;
    assign sda_oe_n  = oen_q;
    assign mem_req   = req_q;
    assign row_touch = touch_q;
endmodule : serial_memory_read_path

`default_nettype wire

// ===== dv/mem_read_props.sv
/*
 * concurrent checks on the pins of the serial memory read path.
 * assumes a bus clock far slower than clk, driven by a synchronous master.
 */
`timescale 1ns/100ps
`default_nettype none

module mem_read_props
    import serial_mem_pkg::*;
(
    input wire logic          clk,       // system clock
    input wire logic          rst,       // async reset, high
    input wire logic          scl_i,     // bus clock pin
    input wire logic          sda_i,     // resolved data line
    input wire logic          sda_o,     // drive value
    input wire logic          sda_oe_n,  // low while driving
    input wire mem_req_type   mem_req,   // array read
    input wire row_touch_type row_touch  // endurance event
);
    // ==========================================================
    // common clocking
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_touch_with_read: assert property (
        mem_req.rd |-> row_touch.valid && row_touch.row == mem_req.addr[ADDR_W-1:ROW_LSB])
        else $error("row touch missing or wrong row");
    a_touch_only_read: assert property (row_touch.valid |-> mem_req.rd)
        else $error("row touch without read");
    a_rd_pulse: assert property (mem_req.rd |=> !mem_req.rd)
        else $error("read request longer than one cycle");
    a_read_scl_high: assert property (mem_req.rd |-> scl_i)
        else $error("read request outside clock high");
    a_drive_low_only: assert property (sda_o == 1'b0)
        else $error("data drive value not low");
    a_change_scl_low: assert property ($changed(sda_oe_n) |-> !scl_i)
        else $error("data changed while clock high");
    a_drive_stands: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*8])
        else $error("driven bit too short");
    a_stop_release: assert property ((scl_i && $rose(sda_i)) |=> sda_oe_n [*8])
        else $error("line driven after stop");
    a_start_release: assert property ((scl_i && $fell(sda_i)) |=> sda_oe_n [*8])
        else $error("line driven after start");
endmodule : mem_read_props

bind serial_memory_read_path mem_read_props u_props (
    .clk       (clk),
    .rst       (rst),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .sda_o     (sda_o),
    .sda_oe_n  (sda_oe_n),
    .mem_req   (mem_req),
    .row_touch (row_touch)
);

`default_nettype wire

// ===== dv/i2c_ctrl_model.sv
/*
 * behavioural two-wire bus controller, 125 ns bus clock period.
 * assumes a pulled-up data line resolved by the bench; drives on clk rise.
 */
`timescale 1ns/100ps
`default_nettype none

module i2c_ctrl_model (
    input  wire logic clk,    // system clock
    output logic      scl,    // bus clock
    output logic      sda_m,  // open-drain drive, 1 releases
    input  wire logic sda     // resolved line
);
    // ==========================================================
    // idle bus: both lines released high
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic start_c;
        sda_m <= 1'b1;
        tick(6);
        scl <= 1'b1;
        tick(6);
        sda_m <= 1'b0;
        tick(6);
        scl <= 1'b0;
        tick(6);
    endtask : start_c

    task automatic stop_c;
        sda_m <= 1'b0;
        tick(6);
        scl <= 1'b1;
        tick(6);
        sda_m <= 1'b1;
        tick(12);
    endtask : stop_c

    task automatic bit_c(input logic b, output logic r);
        sda_m <= b;
        tick(6);
        scl <= 1'b1;
        tick(6);
        r = sda;
        tick(7);
        scl <= 1'b0;
        tick(6);
    endtask : bit_c

    task automatic bits8(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--)
            bit_c(d[i], q[i]);
    endtask : bits8
endmodule : i2c_ctrl_model

`default_nettype wire

// ===== dv/test_serial_memory_read_path.sv
/*
 * self-checking bench: random, current and sequential reads, terminations.
 * assumes the array model answers one clk after each read request.
 */
`timescale 1ns/100ps
`default_nettype none

module test_serial_memory_read_path;
    import serial_mem_pkg::*;
    localparam logic [3:0] DEV_TYPE = 4'h5;  // arbitrary type code
    localparam logic [2:0] SEL      = 3'h6;  // strap value
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    logic          scl;
    logic          sda_m;
    logic          sda;
    logic          sda_o;
    logic          sda_oe_n;
    logic [2:0]    pins = SEL;
    logic [7:0]    mem_rdata = 8'h00;
    mem_req_type   mem_req;
    row_touch_type row_touch;
    logic [7:0]    q;
    logic          r;
    int            bad_count = 0;
    int            tests_run = 0;
    int            touches   = 0;
    logic [9:0]    last_row  = 10'h000;

    // ==========================================================
    // clock, wire, array
    always #2.5 clk = ~clk;
    // pull-up wins unless someone pulls low
    assign sda = sda_m & (sda_oe_n | sda_o);

    function automatic logic [7:0] pat(input logic [12:0] a);
        return a[7:0] ^ {3'h0, a[12:8]};
    endfunction : pat

    always @(posedge clk) mem_rdata <= pat(mem_req.addr);

    // endurance events: counted, last row kept for the scenarios
    always @(posedge clk)
        if (row_touch.valid)
        begin
            touches  <= touches + 1;
            last_row <= row_touch.row;
        end

    serial_memory_read_path #(.DEVICE_TYPE(DEV_TYPE)) DUT (
        .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .device_select_pins(pins), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .row_touch(row_touch));
    i2c_ctrl_model M (.clk(clk), .scl(scl), .sda_m(sda_m), .sda(sda));

    // ==========================================================
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    // start plus target byte; ack is low when expected
    task automatic dev(input logic rw, input logic [2:0] s, input logic nak);
        M.start_c();
        M.bits8({DEV_TYPE, s, rw}, q);
        M.bit_c(1'b1, r);
        check(r, nak);
    endtask : dev

    task automatic rd(input logic [12:0] a, input logic ack_bit);
        M.bits8(8'hFF, q);
        check(q, pat(a));
        M.bit_c(ack_bit, r);
    endtask : rd

    // ==========================================================
    // scenarios
    task automatic sc_random;
        int t0;
        t0 = touches;
        dev(1'b0, SEL, 1'b0);
        M.bits8(8'hFF, q);
        M.bit_c(1'b1, r);
        check(r, 1'b0);
        M.bits8(8'hFE, q);
        M.bit_c(1'b1, r);
        check(r, 1'b0);
        dev(1'b1, SEL, 1'b0);
        rd(13'h1FFE, 1'b0);
        check(last_row, 10'h3FF);
        rd(13'h1FFF, 1'b0);
        rd(13'h0000, 1'b1);
        M.stop_c();
        check(16'(touches - t0), 16'h0003);
        check(last_row, 10'h000);
    endtask : sc_random

    task automatic sc_current;
        dev(1'b1, SEL, 1'b0);
        rd(13'h0001, 1'b1);
        dev(1'b1, SEL, 1'b0);
        rd(13'h0002, 1'b1);
        M.stop_c();
        check(sda_oe_n, 1'b1);
    endtask : sc_current

    task automatic sc_mismatch;
        int t0;
        t0 = touches;
        dev(1'b1, 3'h1, 1'b1);
        M.stop_c();
        check(16'(touches - t0), 16'h0000);
        dev(1'b1, SEL, 1'b0);
        rd(13'h0003, 1'b1);
        M.stop_c();
    endtask : sc_mismatch

    task automatic sc_ack_slot;
        dev(1'b1, SEL, 1'b0);
        M.bits8(8'hFF, q);
        check(q, pat(13'h0004));
        M.stop_c();
        check(sda_oe_n, 1'b1);
        dev(1'b1, SEL, 1'b0);
        M.bits8(8'hFF, q);
        check(q, pat(13'h0005));
        dev(1'b1, SEL, 1'b0);
        rd(13'h0006, 1'b1);
        M.stop_c();
    endtask : sc_ack_slot

    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        sc_random();
        sc_current();
        sc_mismatch();
        sc_ack_slot();
        stop_test();
    end

    initial
    begin
        repeat (50000) @(posedge clk);
        bad_count++;
        stop_test();
    end
endmodule : test_serial_memory_read_path

`default_nettype wire
